// ### design/sct_pkg.sv
// Shared constants, register map and carrier types of the serial unit
// How it works
// - Transmit-end request raised when last bit leaves with nothing held.
// - Request drops on holding-empty read-then-clear, end clear or enable off.
// - Clock-output select matters only in async mode with internal clock.
// - Async: 00 internal no pin, 01 internal clock out, 1x external in.
// - Sync: source 0 drives clock out, source 1 takes clock from pin.
// - Async clock driven out runs at the bit rate.
// - Status register is 8 bits, reset and standby load 0x84.
// - Status bits 7..0: empty, full, overrun, framing, parity, end, mpb, multiproc_bit_to_send.
// - Writing 1 to flags does nothing; 0 clears only after read as 1.
// - Transmit-end and received multiprocessor bit ignore writes.
// - Holding-empty cleared by read-then-write-0 or by a DMA data write.
// - Holding-empty set on reset, standby, enable off, or shift load.
// - With transmitter on, sending starts once holding-empty is cleared.
// - With transmitter off, holding-empty stays at 1.
package sct_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SCT_MODE_OFS = 8'h00;
    localparam logic [7:0] SCT_CTRL_OFS = 8'h04;
    localparam logic [7:0] SCT_STAT_OFS = 8'h08;
    localparam logic [7:0] SCT_HOLD_OFS = 8'h0c;
    localparam logic [7:0] SCT_RATE_OFS = 8'h10;
    localparam logic [7:0] SCT_EVST_OFS = 8'h14;
    localparam logic [7:0] SCT_EVCL_OFS = 8'h18;
    localparam logic [7:0] SCT_EVEN_OFS = 8'h1c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SCT_MODE_SYNC_BIT = 7;
    localparam int SCT_CTRL_TE_BIT = 5;
    localparam int SCT_CTRL_TX_END_IRQ_ENABLE_BIT = 2;
    localparam int SCT_CTRL_CKS_BIT = 1;
    localparam int SCT_CTRL_CKO_BIT = 0;
    localparam logic [7:0] SCT_STAT_RESET = 8'h84;
    localparam logic [7:0] SCT_STAT_FLAG_MASK = 8'hf8;
    localparam logic [7:0] SCT_RATE_RESET = 8'h00;
    localparam int SCT_EV_TX_END = 0;
    localparam int SCT_EV_TX_EMPTY = 1;
    localparam int SCT_EV_RX = 2;
    localparam int SCT_EV_W = 3;

    // ------------------------------------------------------------
    // Frame shape
    // ------------------------------------------------------------
    localparam logic [3:0] SCT_ASYNC_LAST = 4'h9;
    localparam logic [3:0] SCT_SYNC_LAST = 4'h7;
    localparam logic [3:0] SCT_PHASE_LAST = 4'hf;
    localparam int SCT_PHASE_HALF_BIT = 3;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic tx_enable_bit;
        logic tx_end_irq_enable;
        logic clock_source_select;
        logic clock_output_select;
    } sct_ctrl_t;

    typedef struct packed {
        logic tx_holding_empty;
        logic rx_full_flag;
        logic overrun_flag;
        logic framing_error_flag;
        logic parity_error_flag;
        logic tx_end_flag;
        logic multiproc_bit_received;
        logic multiproc_bit_to_send;
    } sct_status_t;

    typedef struct packed {
        logic rx_full_set;
        logic overrun_set;
        logic framing_set;
        logic parity_set;
    } sct_rx_events_t;

endpackage

// ### design/sct_tx_shift.sv
// Transmit shifter: moves held data into the shift register and sends it
`timescale 1ns/1ps
`default_nettype none

module sct_tx_shift
    import sct_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic bit_tick,
    input wire logic sync_mode,
    input wire logic hold_valid,
    input wire logic [7:0] hold_data,
    output logic load,
    output logic frame_done,
    output logic txd,
    output logic busy
);

    typedef enum logic [1:0] {SCT_IDLE, SCT_ARM, SCT_RUN} sct_tx_state_t;

    sct_tx_state_t state;
    logic [9:0] tx_shift_reg;
    logic [3:0] bit_count;
    logic [3:0] last_index;
    logic [9:0] frame_word;
    logic at_last;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    // Async frame carries start and stop bits, sync frame only data
    assign last_index = sync_mode ? SCT_SYNC_LAST : SCT_ASYNC_LAST;
    assign frame_word = sync_mode ? {2'b11, hold_data}
                                  : {1'b1, hold_data, 1'b0};
    assign at_last = (bit_count == last_index);
    assign busy = (state != SCT_IDLE);

    // Load from the holding register when idle, or back to back at end
    always_comb
    begin
        load = 1'b0;
        case (state)
            SCT_IDLE: load = enable && hold_valid;
            SCT_RUN: load = enable && bit_tick && at_last && hold_valid;
            default: load = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // First bit waits for a bit boundary so the start bit is full length
    always_ff @(posedge clock)
    begin
        frame_done <= 1'b0;
        if (reset || !enable)
        begin
            state <= SCT_IDLE;
            tx_shift_reg <= '1;
            bit_count <= '0;
            txd <= 1'b1;
        end
        else
        begin
            case (state)
                SCT_IDLE:
                begin
                    if (load)
                    begin
                        tx_shift_reg <= frame_word;
                        state <= SCT_ARM;
                    end
                end
                SCT_ARM:
                begin
                    if (bit_tick)
                    begin
                        txd <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        bit_count <= '0;
                        state <= SCT_RUN;
                    end
                end
                SCT_RUN:
                begin
                    if (bit_tick)
                    begin
                        if (!at_last)
                        begin
                            txd <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                            bit_count <= bit_count + 4'h1;
                        end
                        else if (load)
                        begin
                            // Continuous sending: no idle gap
                            txd <= frame_word[0];
                            tx_shift_reg <= {1'b1, frame_word[9:1]};
                            bit_count <= '0;
                        end
                        else
                        begin
                            txd <= 1'b1;
                            frame_done <= 1'b1;
                            state <= SCT_IDLE;
                        end
                    end
                end
                default: state <= SCT_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// ### design/sct_serial_unit.sv
// Serial unit transmit status, clock selection and Wishbone registers
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sct_serial_unit
    import sct_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic standby,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dma_tx_write,
    input wire logic [7:0] dma_tx_data,
    input wire sct_rx_events_t rx_events,
    input wire logic rx_multiproc_bit,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    output logic txd,
    output logic tx_end_request,
    output logic irq
);

    logic sync_mode;
    sct_ctrl_t ctrl;
    sct_status_t stat;
    logic [7:0] tx_holding_reg;
    logic [7:0] rate;
    logic [7:0] read_armed;
    logic [SCT_EV_W-1:0] ev_status;
    logic [SCT_EV_W-1:0] ev_enable;
    logic [SCT_EV_W-1:0] ev_set;
    logic access;
    logic wr;
    logic rd;
    logic wr_lo;
    logic [31:0] next_rdata;
    logic status_wr;
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] div_count;
    logic int_tick16;
    logic tick16;
    logic [3:0] phase;
    logic phase_wrap;
    logic bit_tick;
    logic internal_clk;
    logic tx_load;
    logic tx_done;
    logic tx_busy;
    logic hold_clear_sw;
    logic hold_clear;
    logic init;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // One wait state: ack one cycle after the strobe, dropped after
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;
    assign rd = access && !wb_we_i;
    assign wr_lo = wr && wb_sel_i[0];
    assign init = reset || standby;

    always_ff @(posedge clock)
    begin
        if (reset)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= access;
    end

    // Read mux; unmapped and write-only offsets read as zero
    always_comb
    begin
        next_rdata = '0;
        case (wb_adr_i)
            SCT_MODE_OFS: next_rdata[SCT_MODE_SYNC_BIT] = sync_mode;
            SCT_CTRL_OFS:
            begin
                next_rdata[SCT_CTRL_TE_BIT] = ctrl.tx_enable_bit;
                next_rdata[SCT_CTRL_TX_END_IRQ_ENABLE_BIT] = ctrl.tx_end_irq_enable;
                next_rdata[SCT_CTRL_CKS_BIT] = ctrl.clock_source_select;
                next_rdata[SCT_CTRL_CKO_BIT] = ctrl.clock_output_select;
            end
            SCT_STAT_OFS: next_rdata[7:0] = stat;
            SCT_HOLD_OFS: next_rdata[7:0] = tx_holding_reg;
            SCT_RATE_OFS: next_rdata[7:0] = rate;
            SCT_EVST_OFS: next_rdata[SCT_EV_W-1:0] = ev_status;
            SCT_EVEN_OFS: next_rdata[SCT_EV_W-1:0] = ev_enable;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            wb_dat_o <= '0;
        else if (rd)
            wb_dat_o <= next_rdata;
    end

    // ------------------------------------------------------------
    // Mode, control, holding and rate registers
    // ------------------------------------------------------------
    // Mode is written first by software, then the clock selects
    always_ff @(posedge clock)
    begin
        if (reset)
            sync_mode <= 1'b0;
        else if (wr_lo && wb_adr_i == SCT_MODE_OFS)
            sync_mode <= wb_dat_i[SCT_MODE_SYNC_BIT];
    end

    always_ff @(posedge clock)
    begin
        if (init)
            ctrl <= '0;
        else if (wr_lo && wb_adr_i == SCT_CTRL_OFS)
        begin
            ctrl.tx_enable_bit <= wb_dat_i[SCT_CTRL_TE_BIT];
            ctrl.tx_end_irq_enable <= wb_dat_i[SCT_CTRL_TX_END_IRQ_ENABLE_BIT];
            ctrl.clock_source_select <= wb_dat_i[SCT_CTRL_CKS_BIT];
            ctrl.clock_output_select <= wb_dat_i[SCT_CTRL_CKO_BIT];
        end
    end

    // DMA and CPU share the holding register; DMA wins a same-cycle clash
    always_ff @(posedge clock)
    begin
        if (reset)
            tx_holding_reg <= '0;
        else if (dma_tx_write)
            tx_holding_reg <= dma_tx_data;
        else if (wr_lo && wb_adr_i == SCT_HOLD_OFS)
            tx_holding_reg <= wb_dat_i[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            rate <= SCT_RATE_RESET;
        else if (wr_lo && wb_adr_i == SCT_RATE_OFS)
            rate <= wb_dat_i[7:0];
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    assign status_wr = wr_lo && wb_adr_i == SCT_STAT_OFS;

    // Remember which flags were seen at 1; a later 0 write clears those
    always_ff @(posedge clock)
    begin
        if (init)
            read_armed <= '0;
        else if (rd && wb_adr_i == SCT_STAT_OFS)
            read_armed <= stat & SCT_STAT_FLAG_MASK;
        else if (status_wr)
            read_armed <= '0;
    end

    assign hold_clear_sw = status_wr && read_armed[7] && !wb_dat_i[7];
    assign hold_clear = hold_clear_sw || dma_tx_write;

    // Holding-empty: any set source wins over a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (init)
            stat.tx_holding_empty <= SCT_STAT_RESET[7];
        else if (!ctrl.tx_enable_bit || tx_load)
            stat.tx_holding_empty <= 1'b1;
        else if (hold_clear)
            stat.tx_holding_empty <= 1'b0;
    end

    // Receive-side flags: set by receive events, clear after read as 1
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_rx_flag
            logic flag;
            always_ff @(posedge clock)
            begin
                if (init)
                    flag <= SCT_STAT_RESET[6-i];
                else if (rx_events[3-i])
                    flag <= 1'b1;
                else if (status_wr && read_armed[6-i] && !wb_dat_i[6-i])
                    flag <= 1'b0;
            end
        end
    endgenerate

    assign stat.rx_full_flag = g_rx_flag[0].flag;
    assign stat.overrun_flag = g_rx_flag[1].flag;
    assign stat.framing_error_flag = g_rx_flag[2].flag;
    assign stat.parity_error_flag = g_rx_flag[3].flag;

    // End flag is hardware-only; new data accepted clears it
    always_ff @(posedge clock)
    begin
        if (init)
            stat.tx_end_flag <= SCT_STAT_RESET[2];
        else if (tx_done)
            stat.tx_end_flag <= 1'b1;
        else if (hold_clear && ctrl.tx_enable_bit)
            stat.tx_end_flag <= 1'b0;
    end

    // Received multiprocessor bit follows the receiver, never software
    always_ff @(posedge clock)
    begin
        if (init)
            stat.multiproc_bit_received <= SCT_STAT_RESET[1];
        else
            stat.multiproc_bit_received <= rx_multiproc_bit;
    end

    always_ff @(posedge clock)
    begin
        if (init)
            stat.multiproc_bit_to_send <= SCT_STAT_RESET[0];
        else if (status_wr)
            stat.multiproc_bit_to_send <= wb_dat_i[0];
    end

    // Request drops with the flag or the enable
    assign tx_end_request = stat.tx_end_flag
                            && ctrl.tx_end_irq_enable;

    // ------------------------------------------------------------
    // Clock pin and bit timing
    // ------------------------------------------------------------
    // Two-stage synchroniser; edges compare the second stage with a delayed copy of it
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sck_meta <= 1'b1;
            sck_sync <= 1'b1;
            sck_prev <= 1'b1;
        end
        else
        begin
            sck_meta <= sck_in;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
        end
    end

    assign sck_rise = sck_sync && !sck_prev;
    assign sck_fall = !sck_sync && sck_prev;
    assign internal_clk = !ctrl.clock_source_select;

    // Internal divider gives sixteen ticks per bit
    always_ff @(posedge clock)
    begin
        if (reset || div_count == rate)
            div_count <= '0;
        else
            div_count <= div_count + 8'h01;
    end

    assign int_tick16 = (div_count == rate);
    // External async clock already runs at sixteen times the bit rate
    assign tick16 = internal_clk ? int_tick16 : sck_rise;

    always_ff @(posedge clock)
    begin
        if (reset)
            phase <= '0;
        else if (tick16)
            phase <= phase + 4'h1;
    end

    assign phase_wrap = tick16 && (phase == SCT_PHASE_LAST);
    // External sync clock: one bit per falling edge of the pin
    assign bit_tick = (sync_mode && !internal_clk) ? sck_fall
                                                   : phase_wrap;

    // Drive the pin only for the selected internal-clock cases
    always_comb
    begin
        sck_oe_n = 1'b1;
        if (internal_clk)
        begin
            if (sync_mode)
                sck_oe_n = 1'b0;
            else if (ctrl.clock_output_select)
                sck_oe_n = 1'b0;
        end
    end

    // Output clock period is sixteen ticks, which is one bit
    always_ff @(posedge clock)
    begin
        if (reset)
            sck_out <= 1'b1;
        else if (sync_mode && !tx_busy)
            sck_out <= 1'b1;
        else
            sck_out <= phase[SCT_PHASE_HALF_BIT];
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    sct_tx_shift u_tx (
        .clock(clock),
        .reset(init),
        .enable(ctrl.tx_enable_bit),
        .bit_tick(bit_tick),
        .sync_mode(sync_mode),
        .hold_valid(!stat.tx_holding_empty),
        .hold_data(tx_holding_reg),
        .load(tx_load),
        .frame_done(tx_done),
        .txd(txd),
        .busy(tx_busy)
    );

    // ------------------------------------------------------------
    // Event status, clear and enable
    // ------------------------------------------------------------
    assign ev_set[SCT_EV_TX_END] = tx_done;
    assign ev_set[SCT_EV_TX_EMPTY] = tx_load;
    assign ev_set[SCT_EV_RX] = |rx_events;

    // New event beats a simultaneous clear so nothing is lost
    always_ff @(posedge clock)
    begin
        if (reset)
            ev_status <= '0;
        else if (wr_lo && wb_adr_i == SCT_EVCL_OFS)
            ev_status <= (ev_status & ~wb_dat_i[SCT_EV_W-1:0]) | ev_set;
        else
            ev_status <= ev_status | ev_set;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            ev_enable <= '0;
        else if (wr_lo && wb_adr_i == SCT_EVEN_OFS)
            ev_enable <= wb_dat_i[SCT_EV_W-1:0];
    end

    assign irq = |(ev_status & ev_enable);

endmodule
`default_nettype wire

// ### tb/sct_serial_unit_assertions.sv
// Port-level checker for the serial unit
`timescale 1ns/1ps
`default_nettype none
module sct_chk
    import sct_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic standby,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic dma_tx_write,
    input wire logic [7:0] dma_tx_data,
    input wire sct_rx_events_t rx_events,
    input wire logic rx_multiproc_bit,
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic txd,
    input wire logic tx_end_request,
    input wire logic irq
);
    // -----------
    // Relations
    // -----------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // Control write at the edge that takes it
    wire logic ctl_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o
        & wb_sel_i[0] & (wb_adr_i == SCT_CTRL_OFS);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    AST_READ_UPPER: assert property (
        wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data wider than eight bits");
    AST_RESET_OUT: assert property ($past(reset) |->
        !wb_ack_o && txd && sck_oe_n && !tx_end_request && !irq)
        else $error("outputs not at reset values");
    AST_TX_END_IRQ_ENABLE_OFF: assert property (
        ctl_wr && !wb_dat_i[SCT_CTRL_TX_END_IRQ_ENABLE_BIT] |=> !tx_end_request [*2])
        else $error("end request kept with enable off");
    AST_EXT_PIN: assert property (
        ctl_wr && wb_dat_i[SCT_CTRL_CKS_BIT] |=> sck_oe_n [*2])
        else $error("clock pin driven with external source");
    AST_STANDBY: assert property (standby |=> !tx_end_request)
        else $error("end request after standby");
    CV_END: cover property ($rose(tx_end_request));
    CV_PIN: cover property ($fell(sck_oe_n));
    CV_IRQ: cover property ($rose(irq));
endmodule
bind sct_serial_unit sct_chk u_chk (
    .clock(clock), .reset(reset), .standby(standby),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data),
    .rx_events(rx_events), .rx_multiproc_bit(rx_multiproc_bit),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .txd(txd), .tx_end_request(tx_end_request), .irq(irq)
);
`default_nettype wire

// ### tb/sct_peer.sv
// Remote serial peer: external clock source and frame receiver
`timescale 1ns/1ps
`default_nettype none
module sct_peer
    import sct_pkg::*;
(
    input wire logic clock,
    input wire logic txd,
    input wire logic sck_run,
    input var int bit_clocks,
    output logic sck_in,
    output logic [7:0] rx_byte,
    output logic rx_stop,
    output int rx_count
);
    // -----------
    // Peer
    // -----------
    initial sck_in = 1'b1;
    initial rx_count = 0;
    // 16x bit clock; parks high like the synchroniser's reset value
    always #100 if (sck_run || !sck_in) sck_in = ~sck_in;
    // Sample mid-bit; tolerates the pin synchroniser delay
    always
    begin
        @(negedge txd);
        repeat (bit_clocks / 2) @(posedge clock);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_clocks) @(posedge clock);
            rx_byte[i] = txd;
        end
        repeat (bit_clocks) @(posedge clock);
        rx_stop = txd;
        rx_count++;
    end
endmodule
`default_nettype wire

// ### tb/sct_serial_unit_tb_top.sv
// Self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
module sct_serial_unit_tb_top
    import sct_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic standby = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic dma_w = 1'b0;
    logic [7:0] dma_d = 8'h00;
    sct_rx_events_t rx_ev = '0;
    logic rx_mpb = 1'b0;
    logic sck_run = 1'b0;
    int bit_clocks = 16;
    logic sck_in, sck_out, sck_oe_n, txd, ter, irq, ack, rx_stop;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic [7:0] rx_byte;
    int rx_count;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    time t0;
    // Sync, source, output select, expected pin enable
    logic [3:0] tbl [8] = '{4'h1, 4'h2, 4'h5, 4'h7, 4'h8, 4'ha, 4'hd, 4'hf};

    sct_serial_unit DUT (
        .clock(clock), .reset(reset), .standby(standby), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .dma_tx_write(dma_w), .dma_tx_data(dma_d), .rx_events(rx_ev),
        .rx_multiproc_bit(rx_mpb), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .txd(txd), .tx_end_request(ter), .irq(irq)
    );
    sct_peer peer (
        .clock(clock), .txd(txd), .sck_run(sck_run),
        .bit_clocks(bit_clocks), .sck_in(sck_in), .rx_byte(rx_byte),
        .rx_stop(rx_stop), .rx_count(rx_count)
    );

    // -----------
    // Clock, watchdog and tasks
    // -----------
    always #12.5 clock = ~clock;
    // Run needs a few thousand cycles; far above that means a hang
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack, release after it
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        q = dat_o;
        req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask

    // -----------
    // Main sequence
    // -----------
    initial
    begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd(SCT_STAT_OFS, 8'h84);
        rd(8'h20, 8'h00);
        chk(ter, 1'b0);
        wr(SCT_STAT_OFS, 8'hff);
        rd(SCT_STAT_OFS, 8'h85);
        wr(SCT_STAT_OFS, 8'h00);
        rd(SCT_STAT_OFS, 8'h84);
        wr(SCT_STAT_OFS, 8'h00);
        wr(SCT_MODE_OFS, 8'h00);
        wr(SCT_CTRL_OFS, 8'h24);
        chk(ter, 1'b1);
        wr(SCT_CTRL_OFS, 8'h20);
        chk(ter, 1'b0);
        wr(SCT_CTRL_OFS, 8'h24);
        // Unarmed clear must not start a frame
        wr(SCT_HOLD_OFS, 8'ha5);
        wr(SCT_STAT_OFS, 8'h00);
        rd(SCT_STAT_OFS, 8'h84);
        wr(SCT_STAT_OFS, 8'h00);
        chk(ter, 1'b0);
        wait (rx_count == 1);
        chk({rx_stop, rx_byte}, 9'h1a5);
        wait (ter === 1'b1);
        rd(SCT_STAT_OFS, 8'h84);
        // DMA fill of the holding register
        @(posedge clock);
        dma_d <= 8'h3c;
        dma_w <= 1'b1;
        @(posedge clock);
        dma_w <= 1'b0;
        wait (rx_count == 2);
        chk(rx_byte, 8'h3c);
        wait (ter === 1'b1);
        // Event status, enable and clear
        rd(SCT_EVST_OFS, 8'h03);
        wr(SCT_EVEN_OFS, 8'h01);
        @(negedge clock);
        chk(irq, 1'b1);
        wr(SCT_EVEN_OFS, 8'h00);
        @(negedge clock);
        chk(irq, 1'b0);
        wr(SCT_EVEN_OFS, 8'h01);
        wr(SCT_EVCL_OFS, 8'h01);
        @(negedge clock);
        chk(irq, 1'b0);
        rd(SCT_EVST_OFS, 8'h02);
        // External 16x clock: bit is 16 pin periods of 8 clocks
        bit_clocks <= 128;
        sck_run <= 1'b1;
        wr(SCT_CTRL_OFS, 8'h26);
        chk(sck_oe_n, 1'b1);
        wr(SCT_HOLD_OFS, 8'h5a);
        rd(SCT_STAT_OFS, 8'h84);
        wr(SCT_STAT_OFS, 8'h00);
        wait (rx_count == 3);
        chk(rx_byte, 8'h5a);
        wait (ter === 1'b1);
        sck_run <= 1'b0;
        bit_clocks <= 16;
        for (int i = 0; i < 8; i++)
        begin
            wr(SCT_MODE_OFS, {tbl[i][3], 7'h00});
            wr(SCT_CTRL_OFS, {6'h00, tbl[i][2:1]});
            @(negedge clock);
            chk(sck_oe_n, tbl[i][0]);
        end
        wr(SCT_MODE_OFS, 8'h00);
        wr(SCT_CTRL_OFS, 8'h01);
        @(posedge sck_out);
        t0 = $time;
        @(posedge sck_out);
        chk(32'($time - t0), 32'd400);
        // Clocked-sync frame of ones: clock back high once it ends
        wr(SCT_MODE_OFS, 8'h80);
        wr(SCT_CTRL_OFS, 8'h24);
        wr(SCT_HOLD_OFS, 8'hff);
        rd(SCT_STAT_OFS, 8'h84);
        wr(SCT_STAT_OFS, 8'h00);
        chk(ter, 1'b0);
        wait (ter === 1'b1);
        @(negedge clock);
        chk(sck_out, 1'b1);
        wr(SCT_CTRL_OFS, 8'h00);
        // Receive flag: set by event, cleared after read
        @(posedge clock);
        rx_ev <= 4'h8;
        rx_mpb <= 1'b1;
        @(posedge clock);
        rx_ev <= 4'h0;
        rd(SCT_STAT_OFS, 8'hc6);
        wr(SCT_STAT_OFS, 8'h00);
        rd(SCT_STAT_OFS, 8'h86);
        rx_mpb <= 1'b0;
        wr(SCT_CTRL_OFS, 8'h04);
        chk(ter, 1'b1);
        @(posedge clock);
        standby <= 1'b1;
        @(posedge clock);
        standby <= 1'b0;
        @(negedge clock);
        chk(ter, 1'b0);
        rd(SCT_STAT_OFS, 8'h84);
        test_done();
    end
endmodule
`default_nettype wire
